// file: logic/cpu_pc_flags_pkg.sv
// Constants, enumerations and carrier structs of the program counter, flag and address unit
package cpu_pc_flags_pkg;

  // Vector and page constants
  localparam logic [15:0] VEC_HI_ADDR  = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR  = 16'hFFFF;
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] IP_STEP      = 16'h0001;

  // Flag register bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;

  // Flag register fixed ones and reset value
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;

  // Decimal adjust constants
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam logic [7:0] BCD_MAX    = 8'h99;
  localparam logic [3:0] NIBBLE_MAX = 4'h9;

  // Register port offsets
  localparam logic [3:0] REG_IP     = 4'h0;
  localparam logic [3:0] REG_FLAGS  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  typedef enum logic [4:0] {
    OP_NONE, OP_FETCH, OP_JUMP, OP_BRANCH, OP_BIT_BRANCH, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
    OP_LOAD8, OP_LOAD16, OP_DAA, OP_SHL, OP_SHR, OP_CLEAR_MASK, OP_SET_FLAGS, OP_IRQ_STACKED
  } op_e;

  typedef enum logic [3:0] {
    COND_ALWAYS, COND_EQ, COND_NE, COND_CS, COND_CC, COND_MI, COND_PL,
    COND_GT, COND_GE, COND_LE, COND_LT
  } cond_e;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_REGISTER, MODE_LITERAL8, MODE_LITERAL16, MODE_ZERO_PAGE
  } mode_e;

  typedef enum logic [2:0] {ST_REQ_HI, ST_REQ_LO, ST_CAP_HI, ST_CAP_LO, ST_RUN} state_e;

  // One command from the instruction sequencer
  typedef struct packed {
    op_e         op;
    cond_e       cond;
    mode_e       mode;
    logic [7:0]  opA;
    logic [7:0]  opB;
    logic [7:0]  offset;
    logic [15:0] target;
    logic        boundary;
  } cmd_s;

  // Memory read request
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } mem_req_s;

  // Effective address answer
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] literal;
  } ea_s;

endpackage

// file: logic/cpu_pc_flags_address_gen.sv
// Program counter, flag register and effective address unit of an 8-bit CPU core
// Operation
// RQ1: Instruction pointer is 16 bits and steps by one per fetched byte.
// RQ2: Jumps, branches, interrupts and returns load a non-sequential target.
// RQ3: After reset the pointer loads the vector read from 0xFFFE and 0xFFFF.
// RQ4: Flag bits 6 and 5 always read as one.
// RQ5: Bit 7 marks signed overflow; signed compare branches test it.
// RQ6: Bit 4 records carry from bit 3 into bit 4 on add and add-with-carry.
// RQ7: Decimal adjust uses half-carry and carry to correct a BCD sum.
// RQ8: Bit 3 is the interrupt mask; one blocks maskable interrupts.
// RQ9: Interrupt service sets the mask after stacking, before the handler runs.
// RQ10: No interrupt at the boundary right after an instruction clearing the mask.
// RQ11: Bit 2 takes the top bit of results and of loaded or stored values.
// RQ12: Bit 1 is set for a zero 8- or 16-bit result, else cleared.
// RQ13: Bit 0 is carry or borrow; shifts and bit-test branches update it.
// RQ14: All memory and registers share one 64-Kbyte space, 16-bit addresses.
// RQ15: Test-and-branch locates operand by mode; target always relative.
// RQ16: Register-operand mode performs no memory access for operands.
// RQ17: Branch offset is a signed byte, sign-extended and added when taken.
// RQ18: Literal operands follow the opcode; 16-bit literals come high byte first.
// RQ19: Zero-page address is 0x00 above the instruction's address byte.
// RQ20: Address arithmetic wraps modulo 65536 and raises no flag.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
module cpu_pc_flags_address_gen
  import cpu_pc_flags_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Sequencer command and interrupt request
  input  wire cmd_s        cmd,
  input  wire logic        irqReq,
  // System memory read port
  output mem_req_s         memReq,
  input  wire logic [7:0]  memData,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // Core state and answers
  output logic      [15:0] ip,
  output logic      [7:0]  flags,
  output ea_s              ea,
  output logic      [7:0]  result,
  output logic             branchTaken,
  output logic             irqGrant,
  output logic             ready
);

  typedef struct packed {
    state_e      fsm;
    logic [15:0] ip;
    logic [7:0]  flags;
    logic [7:0]  vecHi;
    logic        inhibit;
    logic        ready;
    mem_req_s    memReq;
    ea_s         ea;
    logic [7:0]  result;
    logic        branchTaken;
    logic        irqGrant;
    logic [15:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;

  // Branch condition decode, used by the branch path only; bit-test branches compare cond with COND_CS directly
  function automatic logic cond_met(input cond_e c, input logic [7:0] f);
    logic nv;
    nv = f[FLG_N] ^ f[FLG_V];
    case (c)
      COND_ALWAYS: cond_met = 1'b1;
      COND_EQ:     cond_met = f[FLG_Z];
      COND_NE:     cond_met = !f[FLG_Z];
      COND_CS:     cond_met = f[FLG_C];
      COND_CC:     cond_met = !f[FLG_C];
      COND_MI:     cond_met = f[FLG_N];
      COND_PL:     cond_met = !f[FLG_N];
      COND_GT:     cond_met = !(f[FLG_Z] | nv); // [RQ5]
      COND_GE:     cond_met = !nv;               // [RQ5]
      COND_LE:     cond_met = f[FLG_Z] | nv;     // [RQ5]
      COND_LT:     cond_met = nv;                // [RQ5]
      default:     cond_met = 1'b0;
    endcase
  endfunction

  // Relative target; the carry out is dropped so the sum wraps
  function automatic logic [15:0] rel_target(input logic [15:0] p, input logic [7:0] off);
    rel_target = p + {{8{off[7]}}, off}; // [RQ17] [RQ20]
  endfunction

  // Next-state logic
  always_comb begin
    logic [8:0] add9;
    logic [4:0] half5;
    logic [8:0] sub9;
    logic       cin;
    logic       lowAdj;
    logic       highAdj;
    logic       bitVal;
    logic [7:0] fix;
    logic [7:0] res;
    add9    = '0;
    half5   = '0;
    sub9    = '0;
    cin     = s.flags[FLG_C];
    lowAdj  = 1'b0;
    highAdj = 1'b0;
    bitVal  = 1'b0;
    fix     = '0;
    res     = '0;
    next_s  = s;
    // Pulses last one cycle
    next_s.memReq      = '0;
    next_s.ea.valid    = 1'b0;
    next_s.branchTaken = 1'b0;
    next_s.irqGrant    = 1'b0;
    next_s.rdata       = '0;

    case (s.fsm)
      ST_REQ_HI: begin
        next_s.memReq.rd   = 1'b1;
        next_s.memReq.addr = VEC_HI_ADDR; // [RQ3]
        next_s.fsm         = ST_REQ_LO;
      end
      ST_REQ_LO: begin
        next_s.memReq.rd   = 1'b1;
        next_s.memReq.addr = VEC_LO_ADDR; // [RQ3]
        next_s.fsm         = ST_CAP_HI;
      end
      ST_CAP_HI: begin
        next_s.vecHi = memData;
        next_s.fsm   = ST_CAP_LO;
      end
      ST_CAP_LO: begin
        next_s.ip    = {s.vecHi, memData}; // [RQ3]
        next_s.ready = 1'b1;
        next_s.fsm   = ST_RUN;
      end
      ST_RUN: begin
        // Operand address for the command's own mode; the branch target
        // of a test-and-branch never comes from here [RQ15]
        case (cmd.mode)
          MODE_REGISTER: next_s.ea.valid = 1'b0; // [RQ16]
          MODE_LITERAL8: begin
            next_s.ea.valid   = 1'b1;
            next_s.ea.addr    = s.ip;
            next_s.ea.literal = {8'h00, cmd.opA};
          end
          MODE_LITERAL16: begin
            next_s.ea.valid   = 1'b1;
            next_s.ea.addr    = s.ip;
            next_s.ea.literal = {cmd.opA, cmd.opB}; // [RQ18]
          end
          MODE_ZERO_PAGE: begin
            next_s.ea.valid = 1'b1;
            next_s.ea.addr  = {PAGE_ZERO_HI, cmd.opB}; // [RQ19] [RQ14]
          end
          default: next_s.ea.valid = 1'b0;
        endcase

        case (cmd.op)
          OP_FETCH: next_s.ip = s.ip + IP_STEP; // [RQ1] [RQ20]
          OP_JUMP:  next_s.ip = cmd.target;     // [RQ2]
          OP_BRANCH: begin
            if (cond_met(cmd.cond, s.flags)) begin
              next_s.ip          = rel_target(s.ip, cmd.offset); // [RQ2] [RQ17]
              next_s.branchTaken = 1'b1;
            end
          end
          OP_BIT_BRANCH: begin
            bitVal                 = cmd.opA[cmd.opB[2:0]];
            next_s.flags[FLG_C]    = bitVal; // [RQ13]
            if (bitVal == (cmd.cond == COND_CS)) begin
              next_s.ip          = rel_target(s.ip, cmd.offset); // [RQ15]
              next_s.branchTaken = 1'b1;
            end
          end
          OP_ADD, OP_ADC: begin
            cin   = (cmd.op == OP_ADC) ? s.flags[FLG_C] : 1'b0;
            add9  = {1'b0, cmd.opA} + {1'b0, cmd.opB} + {8'h00, cin};
            half5 = {1'b0, cmd.opA[3:0]} + {1'b0, cmd.opB[3:0]} + {4'h0, cin};
            res   = add9[7:0];
            next_s.flags[FLG_H] = half5[4]; // [RQ6]
            next_s.flags[FLG_C] = add9[8];  // [RQ13]
            next_s.flags[FLG_V] = (cmd.opA[7] == cmd.opB[7]) && (res[7] != cmd.opA[7]); // [RQ5]
            next_s.flags[FLG_N] = res[7];          // [RQ11]
            next_s.flags[FLG_Z] = (res == 8'h00); // [RQ12]
            next_s.result       = res;
          end
          OP_SUB, OP_SBC: begin
            cin  = (cmd.op == OP_SBC) ? s.flags[FLG_C] : 1'b0;
            sub9 = {1'b0, cmd.opA} - {1'b0, cmd.opB} - {8'h00, cin};
            res  = sub9[7:0];
            next_s.flags[FLG_C] = sub9[8]; // [RQ13]
            next_s.flags[FLG_V] = (cmd.opA[7] != cmd.opB[7]) && (res[7] != cmd.opA[7]); // [RQ5]
            next_s.flags[FLG_N] = res[7];          // [RQ11]
            next_s.flags[FLG_Z] = (res == 8'h00); // [RQ12]
            next_s.result       = res;
          end
          OP_LOAD8: begin
            next_s.flags[FLG_V] = 1'b0;
            next_s.flags[FLG_N] = cmd.opA[7];          // [RQ11]
            next_s.flags[FLG_Z] = (cmd.opA == 8'h00); // [RQ12]
            next_s.result       = cmd.opA;
          end
          OP_LOAD16: begin
            next_s.flags[FLG_V] = 1'b0;
            next_s.flags[FLG_N] = cmd.target[15];           // [RQ11]
            next_s.flags[FLG_Z] = (cmd.target == 16'h0000); // [RQ12]
          end
          OP_DAA: begin
            // Correction chosen from the flags of the prior BCD add and from the digits of opA
            lowAdj  = s.flags[FLG_H] || (cmd.opA[3:0] > NIBBLE_MAX);
            highAdj = s.flags[FLG_C] || (cmd.opA > BCD_MAX);
            fix     = (highAdj ? BCD_HI_FIX : 8'h00) | (lowAdj ? BCD_LO_FIX : 8'h00);
            res     = cmd.opA + fix; // [RQ7]
            next_s.flags[FLG_C] = s.flags[FLG_C] | highAdj; // [RQ7]
            next_s.flags[FLG_N] = res[7];
            next_s.flags[FLG_Z] = (res == 8'h00);
            next_s.result       = res;
          end
          OP_SHL: begin
            res = {cmd.opA[6:0], 1'b0};
            next_s.flags[FLG_C] = cmd.opA[7]; // [RQ13]
            next_s.flags[FLG_N] = res[7];
            next_s.flags[FLG_Z] = (res == 8'h00);
            next_s.flags[FLG_V] = res[7] ^ cmd.opA[7];
            next_s.result       = res;
          end
          OP_SHR: begin
            res = {1'b0, cmd.opA[7:1]};
            next_s.flags[FLG_C] = cmd.opA[0]; // [RQ13]
            next_s.flags[FLG_N] = 1'b0;
            next_s.flags[FLG_Z] = (res == 8'h00);
            next_s.flags[FLG_V] = cmd.opA[0];
            next_s.result       = res;
          end
          OP_CLEAR_MASK:  next_s.flags[FLG_I] = 1'b0; // [RQ8]
          OP_SET_FLAGS:   next_s.flags = cmd.opA;
          OP_IRQ_STACKED: next_s.flags[FLG_I] = 1'b1; // [RQ9]
          default: next_s.ip = s.ip;
        endcase

        // A mask cleared from one by a command between boundaries holds interrupts off through the next boundary
        if (cmd.boundary) begin
          next_s.irqGrant = irqReq && !s.flags[FLG_I] && !s.inhibit; // [RQ8] [RQ10]
          next_s.inhibit  = 1'b0;
        end else if (s.flags[FLG_I] && !next_s.flags[FLG_I]) begin
          next_s.inhibit  = 1'b1; // [RQ10]
        end
      end
      default: next_s.fsm = ST_REQ_HI;
    endcase

    // Software writes override the command in the same cycle
    if (regWr) begin
      case (regAddr)
        REG_IP:    next_s.ip    = regWdata;
        REG_FLAGS: next_s.flags = regWdata[7:0];
        default:   next_s.ip    = next_s.ip;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_IP:     next_s.rdata = s.ip;
        REG_FLAGS:  next_s.rdata = {8'h00, s.flags};
        REG_STATUS: next_s.rdata = {14'h0000, s.inhibit, s.ready};
        default:    next_s.rdata = 16'h0000;
      endcase
    end
    // Bits 6 and 5 cannot be cleared by any path
    next_s.flags = next_s.flags | FLAGS_FIXED; // [RQ4]
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s       <= '0;
      s.fsm   <= ST_REQ_HI;
      s.flags <= FLAGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign memReq      = s.memReq;
  assign regRdata    = s.rdata;
  assign ip          = s.ip;
  assign flags       = s.flags;
  assign ea          = s.ea;
  assign result      = s.result;
  assign branchTaken = s.branchTaken;
  assign irqGrant    = s.irqGrant;
  assign ready       = s.ready;

  // Checks on the unit's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic run;
  assign run = s.ready && !regWr;

  AST_FIXED_ONES: assert property (flags[6:5] == 2'b11) // [RQ4]
    else $error("flag bits 6 and 5 not one");
  AST_FETCH_STEP: assert property (run && cmd.op == OP_FETCH |=> ip == $past(ip) + 16'h0001) // [RQ1]
    else $error("pointer did not step by one");
  AST_JUMP_LOAD: assert property (run && cmd.op == OP_JUMP |=> ip == $past(cmd.target)) // [RQ2]
    else $error("jump target not loaded");
  AST_RESET_VEC: assert property ($rose(ready) |-> ip == {$past(memData, 2), $past(memData)}) // [RQ3]
    else $error("reset vector not loaded");
  AST_VEC_ORDER: assert property (memReq.rd && memReq.addr == VEC_HI_ADDR
                                  |=> memReq.rd && memReq.addr == VEC_LO_ADDR ##2 ready) // [RQ3]
    else $error("vector fetch order wrong");
  AST_OVERFLOW: assert property (run && cmd.op == OP_ADD && cmd.opA == 8'h7F && cmd.opB == 8'h01
                                 |=> flags[7] && flags[2] && !flags[0]) // [RQ5]
    else $error("overflow flag wrong");
  // Nibbles widened to five bits so the carry into bit 4 survives the sum
  AST_HALF_CARRY: assert property (run && cmd.op == OP_ADD // [RQ6]
                                   |=> flags[4] == (({1'b0, $past(cmd.opA[3:0])}
                                                     + {1'b0, $past(cmd.opB[3:0])}) > 5'h0F))
    else $error("half carry wrong");
  AST_MASK_SET: assert property (run && cmd.op == OP_IRQ_STACKED |=> flags[3] && !irqGrant) // [RQ9]
    else $error("mask not set after stacking");
  AST_NO_IRQ_AFTER_CLEAR: assert property (run && s.inhibit && cmd.boundary |=> !irqGrant) // [RQ10]
    else $error("interrupt taken after mask clear");
  AST_REG_MODE: assert property (run && cmd.mode == MODE_REGISTER |=> !ea.valid) // [RQ16]
    else $error("register mode formed an address");
  AST_ZERO_PAGE: assert property (run && cmd.mode == MODE_ZERO_PAGE
                                  |=> ea.valid && ea.addr == {8'h00, $past(cmd.opB)}) // [RQ19]
    else $error("zero page address wrong");
  AST_BRANCH_SUM: assert property (run && cmd.op == OP_BRANCH && cmd.cond == COND_ALWAYS
                                   |=> branchTaken && ip == $past(ip)
                                       + {{8{$past(cmd.offset[7])}}, $past(cmd.offset)}) // [RQ17]
    else $error("branch target wrong");

  COV_RESET_DONE: cover property ($rose(ready));
  COV_BRANCH:     cover property (branchTaken);
  COV_IRQ:        cover property (irqGrant);
  COV_INHIBIT:    cover property (s.inhibit && cmd.boundary && irqReq);

endmodule

// file: tb/mem_model.sv
// Behavioural system memory answering the reset vector fetch
`timescale 1ns/100ps
module mem_model
  import cpu_pc_flags_pkg::*;
#(
  parameter logic [15:0] VEC_VALUE = 16'hC100
)(
  // Clock
  input  wire logic     clk,
  // Read port
  input  wire mem_req_s memReq,
  output logic [7:0]    memData
);
  initial memData = 8'hA5;

  // One-cycle answer; otherwise inverted so stale data never looks valid
  always @(posedge clk) begin
    if (memReq.rd) begin
      memData <= (memReq.addr == VEC_HI_ADDR) ? VEC_VALUE[15:8] :
                 (memReq.addr == VEC_LO_ADDR) ? VEC_VALUE[7:0] : ~memReq.addr[7:0];
    end else begin
      memData <= ~memData;
    end
  end
endmodule

// file: tb/cpu_pc_flags_address_gen_test.sv
// Self-checking bench of the program counter, flag and address unit
`timescale 1ns/100ps
module cpu_pc_flags_address_gen_test
  import cpu_pc_flags_pkg::*;
;
  localparam logic [15:0] VEC = 16'hC100;
  typedef struct {op_e op; logic [7:0] a, b, res, fl, msk; bit cr;} row_s;
  logic clk = 1'b0, rst_n = 1'b0, irqReq = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, regRdata, ip, rv;
  logic [7:0] memData, flags, result;
  logic branchTaken, irqGrant, ready;
  mem_req_s memReq;
  ea_s ea;
  cmd_s cmd = '0;
  int err_total = 0, num_checks = 0;
  // Ordinary ALU cases, executed in order so carries chain
  row_s rows[13] = '{
    '{OP_ADD, 8'h7F, 8'h01, 8'h80, 8'hFC, 8'hFF, 1}, '{OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h7B, 8'hFF, 1},
    '{OP_ADC, 8'h10, 8'h20, 8'h31, 8'h68, 8'hFF, 1}, '{OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h6D, 8'hEF, 1},
    '{OP_SUB, 8'h80, 8'h01, 8'h7F, 8'hE8, 8'hEF, 1}, '{OP_LOAD16, 8'h80, 8'h00, 8'h00, 8'h04, 8'h06, 0},
    '{OP_LOAD16, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 0}, '{OP_ADD, 8'h15, 8'h27, 8'h3C, 8'h68, 8'hFF, 1},
    '{OP_DAA, 8'h3C, 8'h00, 8'h42, 8'h00, 8'h00, 1}, '{OP_ADD, 8'h19, 8'h28, 8'h41, 8'h78, 8'hFF, 1},
    '{OP_DAA, 8'h41, 8'h00, 8'h47, 8'h00, 8'h00, 1}, '{OP_ADD, 8'h90, 8'h90, 8'h20, 8'hE9, 8'hFF, 1},
    '{OP_DAA, 8'h20, 8'h00, 8'h80, 8'h00, 8'h00, 1}};

  always #5 clk = ~clk;

  cpu_pc_flags_address_gen dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .irqReq(irqReq),
    .memReq(memReq), .memData(memData), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ip(ip), .flags(flags), .ea(ea),
    .result(result), .branchTaken(branchTaken), .irqGrant(irqGrant), .ready(ready));
  mem_model #(.VEC_VALUE(VEC)) mem (.clk(clk), .memReq(memReq), .memData(memData));

  // Verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic cmd_s mk(op_e op, cond_e cd, mode_e md, logic [7:0] a, logic [7:0] b,
                              logic [7:0] off, logic bnd);
    mk = '{op: op, cond: cd, mode: md, opA: a, opB: b, offset: off, target: {a, b},
           boundary: bnd};
  endfunction

  // One command taken at one edge; results sampled just after it
  task automatic issue(input cmd_s c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= '0;
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin regAddr <= a; regWdata <= d; regWr <= 1'b1; end
    @(posedge clk) regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge clk) regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk) #1 chk(regRdata, 16'h0000, "read data lingers");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 chk(flags, 16'h0068, "reset flags");
    chk(ready, 1'b0, "ready in reset");
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk) #1 chk({memReq.rd, memReq.addr}, {1'b1, VEC_HI_ADDR}, "vector hi fetch");
    @(posedge clk) #1 chk({memReq.rd, memReq.addr}, {1'b1, VEC_LO_ADDR}, "vector lo fetch");
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk) #1;
    chk(ip, VEC, "reset vector load");
    foreach (rows[i]) begin
      issue(mk(rows[i].op, COND_ALWAYS, MODE_NONE, rows[i].a, rows[i].b, 8'h00, 1'b0));
      chk(flags & rows[i].msk, rows[i].fl & rows[i].msk, "alu flags");
      if (rows[i].cr) chk(result, rows[i].res, "alu result");
      chk(ip, VEC, "ip moved by alu op");
    end
    // Register port, fixed ones and unmapped place
    reg_wr(REG_FLAGS, 16'h0000);
    reg_rd(REG_FLAGS, rv);
    chk(rv, 16'h0060, "flags fixed bits");
    reg_rd(4'h2, rv);
    chk(rv, 16'h0000, "unmapped read");
    reg_rd(REG_STATUS, rv);
    chk(rv[0], 1'b1, "status ready");
    // Sequential step and wrap, jump and branches
    reg_wr(REG_IP, 16'hFFFF);
    reg_rd(REG_IP, rv);
    chk(rv, 16'hFFFF, "ip write");
    issue(mk(OP_FETCH, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(ip, 16'h0000, "ip wrap");
    chk(flags, 16'h0060, "wrap raised flag");
    issue(mk(OP_JUMP, COND_ALWAYS, MODE_NONE, 8'h12, 8'h34, 8'h00, 1'b0));
    chk(ip, 16'h1234, "jump");
    issue(mk(OP_BRANCH, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'hFE, 1'b0));
    chk({branchTaken, ip}, {1'b1, 16'h1232}, "backward branch");
    @(posedge clk) #1 chk(branchTaken, 1'b0, "taken pulse length");
    issue(mk(OP_BRANCH, COND_EQ, MODE_NONE, 8'h00, 8'h00, 8'h10, 1'b0));
    chk({branchTaken, ip}, {1'b0, 16'h1232}, "untaken branch");
    reg_wr(REG_IP, 16'h0001);
    issue(mk(OP_BRANCH, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'hFD, 1'b0));
    chk(ip, 16'hFFFE, "branch wrap");
    issue(mk(OP_BIT_BRANCH, COND_CS, MODE_NONE, 8'h04, 8'h02, 8'h04, 1'b0));
    chk({branchTaken, ip, flags[FLG_C]}, {1'b1, 16'h0002, 1'b1}, "bit branch");
    // Address modes
    issue(mk(OP_NONE, COND_ALWAYS, MODE_LITERAL16, 8'h12, 8'h34, 8'h00, 1'b0));
    chk({ea.valid, ea.literal}, {1'b1, 16'h1234}, "literal16");
    issue(mk(OP_NONE, COND_ALWAYS, MODE_ZERO_PAGE, 8'hAB, 8'h5A, 8'h00, 1'b0));
    chk({ea.valid, ea.addr}, {1'b1, 16'h005A}, "zero page");
    issue(mk(OP_ADD, COND_ALWAYS, MODE_REGISTER, 8'h01, 8'h02, 8'h00, 1'b0));
    chk({memReq.rd, result}, {1'b0, 8'h03}, "register mode");
    // Interrupt mask and the shadow after clearing it
    reg_wr(REG_FLAGS, 16'h0068);
    irqReq <= 1'b1;
    issue(mk(OP_NONE, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b1));
    chk(irqGrant, 1'b0, "masked grant");
    issue(mk(OP_CLEAR_MASK, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(flags[FLG_I], 1'b0, "mask clear");
    issue(mk(OP_NONE, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b1));
    chk(irqGrant, 1'b0, "grant in shadow");
    issue(mk(OP_NONE, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b1));
    chk(irqGrant, 1'b1, "grant");
    irqReq <= 1'b0;
    issue(mk(OP_IRQ_STACKED, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(flags[FLG_I], 1'b1, "mask after stacking");
    issue(mk(OP_SET_FLAGS, COND_ALWAYS, MODE_NONE, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(flags, 16'h0060, "transfer to flags");
    give_verdict();
  end
endmodule
